// ### verilog/lcdpt_consts.svh
// Offsets, field positions, reset values and counts of the display pin and timing block
`ifndef LCDPT_CONSTS_SVH
`define LCDPT_CONSTS_SVH
// Register word offsets (byte addresses)
`define LCDPT_CTRL_OFS 8'h00
`define LCDPT_ROLE_OFS 8'h04
`define LCDPT_PFUNC_OFS 8'h08
`define LCDPT_STAT_OFS 8'h0C
`define LCDPT_MEM0_OFS 8'h10
`define LCDPT_MEM3_OFS 8'h1C
// Control register field positions
`define LCDPT_MODE_LSB 0
`define LCDPT_SRC_LSB 4
`define LCDPT_SON_BIT 7
`define LCDPT_DIV_LSB 8
`define LCDPT_CLR_BIT 16
// Reset values
`define LCDPT_MODE_RST 3'h0
`define LCDPT_SRC_RST 2'h0
`define LCDPT_DIV_RST 5'h04
`define LCDPT_ROLE_RST 16'h0000
`define LCDPT_PFUNC_RST 16'h0000
// Pins with no shared digital function (arbitrary plain default)
`define LCDPT_DEDICATED 16'h0000
// Sizes
`define LCDPT_NPINS 16
`define LCDPT_NBYTES 16
`endif

// ### verilog/lcdpt_pkg.sv
// Types of the display pin and timing block
package lcdpt_pkg;
  // Mux organisation: code value plus one is the number of commons
  typedef enum logic [2:0] {
    LCDPT_STATIC = 3'h0,
    LCDPT_MUX2 = 3'h1,
    LCDPT_MUX3 = 3'h2,
    LCDPT_MUX4 = 3'h3,
    LCDPT_MUX5 = 3'h4,
    LCDPT_MUX6 = 3'h5,
    LCDPT_MUX7 = 3'h6,
    LCDPT_MUX8 = 3'h7
  } lcdpt_mode_t;
  // Timing source choice
  typedef enum logic [1:0] {
    LCDPT_SRC_AUX = 2'h0,
    LCDPT_SRC_XTAL = 2'h1,
    LCDPT_SRC_VLO = 2'h2,
    LCDPT_SRC_NONE = 2'h3
  } lcdpt_src_t;
endpackage : lcdpt_pkg

// ### verilog/lcdpt_top.sv
// Display pin role decoding, memory and base clock / frame timing with a Wishbone slave
`timescale 1ns/1ns
`default_nettype none
`include "lcdpt_consts.svh"
module lcdpt_top import lcdpt_pkg::*; (
  input wire logic clk_i, // 125 MHz system clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic aux_clock_i, // Auxiliary clock level
  input wire logic crystal_32k_clock_i, // Crystal clock level
  input wire logic very_low_power_osc_clock_i, // Low-power oscillator level
  output logic [15:0] seg_on_o, // Segment pin lit in current common phase
  output logic [15:0] com_active_o, // Common pin is the active common now
  output logic [15:0] lcd_func_o, // Pin carries the display function
  output logic base_tick_o, // One-cycle base clock enable
  output logic frame_start_o, // One-cycle pulse at frame boundary
  output logic [2:0] com_phase_o, // Index of the active common
  output logic polarity_o // Second half of the frame
);

  // Configuration state
  lcdpt_mode_t mux_mode_select_r; // Mux organisation
  lcdpt_src_t timing_source_select_r; // Timing source
  logic [4:0] base_clock_divider_r; // Programmable divider minus one
  logic segments_on_gate_r; // Global segment enable
  logic memory_clear_request_r; // Pending memory clear
  logic [15:0] pin_role_select_reg_r; // One role bit per pin
  logic [15:0] port_function_reg_r; // One function bit per pin
  logic [7:0] display_memory_byte_r [`LCDPT_NBYTES]; // Display memory

  // Bus handshake state
  logic ack_r; // Answer strobe
  logic [31:0] dat_r; // Captured read data
  logic req; // Request present
  logic wr_en; // Write committed at the ack edge
  logic [5:0] word_idx; // Word address
  logic [31:0] rd_mux; // Read selection

  // Timing state
  logic src_lvl; // Selected source level
  logic src_prev_r; // Source level one cycle back
  logic src_edge; // Source rising edge
  logic [4:0] pre_cnt_r; // Programmable divider count
  logic [5:0] mux_cnt_r; // Fixed divider count
  logic [3:0] phase_cnt_r; // Base periods within a frame
  logic [6:0] mux_div; // Fixed divider for this mode
  logic [3:0] mux_n; // Number of commons
  logic [4:0] frame_len; // Base periods per frame
  logic base_tick; // Base clock enable
  logic frame_end; // Last base tick of a frame
  logic [2:0] com_idx; // Active common index
  logic [7:0] com_mask; // Commons allowed in this mode
  logic high_mux; // 5- to 8-mux organisation
  // Pins with no shared digital function always carry the display function
  localparam logic [15:0] dedicated_mask = `LCDPT_DEDICATED;

  // Fixed divider per mode
  function automatic logic [6:0] fixed_div(input lcdpt_mode_t m);
    logic [6:0] d;
    d = 7'h08;
    unique case (m)
      LCDPT_STATIC: d = 7'h40;
      LCDPT_MUX2: d = 7'h20;
      LCDPT_MUX3, LCDPT_MUX4: d = 7'h10;
      LCDPT_MUX5: d = 7'h0C;
      LCDPT_MUX6, LCDPT_MUX7, LCDPT_MUX8: d = 7'h08;
    endcase
    return d;
  endfunction : fixed_div

  // Mode-derived values
  always_comb begin
    mux_div = fixed_div(mux_mode_select_r);
    mux_n = {1'b0, mux_mode_select_r} + 4'h1;
    frame_len = {mux_n, 1'b0};
    high_mux = (mux_mode_select_r >= LCDPT_MUX5);
    com_mask = 8'((9'h001 << mux_n) - 9'h001);
  end

  // Bus decode
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_en = req & wb_we_i & ack_r;
  assign word_idx = wb_adr_i[7:2];

  // Read selection; unmapped words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case ({word_idx, 2'b00})
      `LCDPT_CTRL_OFS: begin
        rd_mux[`LCDPT_MODE_LSB +: 3] = mux_mode_select_r;
        rd_mux[`LCDPT_SRC_LSB +: 2] = timing_source_select_r;
        rd_mux[`LCDPT_SON_BIT] = segments_on_gate_r;
        rd_mux[`LCDPT_DIV_LSB +: 5] = base_clock_divider_r;
        rd_mux[`LCDPT_CLR_BIT] = memory_clear_request_r;
      end
      `LCDPT_ROLE_OFS: rd_mux[15:0] = pin_role_select_reg_r;
      `LCDPT_PFUNC_OFS: rd_mux[15:0] = port_function_reg_r;
      `LCDPT_STAT_OFS: rd_mux[4:0] = {polarity_o, 1'b0, com_idx};
      default: begin
        if ({word_idx, 2'b00} >= `LCDPT_MEM0_OFS && {word_idx, 2'b00} <= `LCDPT_MEM3_OFS) begin
          for (int b = 0; b < 4; b++) begin
            rd_mux[8*b +: 8] = display_memory_byte_r[{word_idx[1:0], 2'(b)}];
          end
        end
      end
    endcase
  end

  // Answer one cycle after the request, drop it the cycle after
  // A held request is answered every other cycle; the ack cycle itself starts no new answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r) begin
        dat_r <= rd_mux;
      end
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // Control register; a software set of the clear request beats the hardware clear
  // Writes land only at the ack edge, so a held request writes once per ack, every other cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mux_mode_select_r <= lcdpt_mode_t'(`LCDPT_MODE_RST);
      timing_source_select_r <= lcdpt_src_t'(`LCDPT_SRC_RST);
      segments_on_gate_r <= 1'b0;
      base_clock_divider_r <= `LCDPT_DIV_RST;
      memory_clear_request_r <= 1'b0;
    end else begin
      if (frame_end & memory_clear_request_r) begin
        memory_clear_request_r <= 1'b0;
      end
      if (wr_en && {word_idx, 2'b00} == `LCDPT_CTRL_OFS) begin
        if (wb_sel_i[0]) begin
          mux_mode_select_r <= lcdpt_mode_t'(wb_dat_i[`LCDPT_MODE_LSB +: 3]);
          timing_source_select_r <= lcdpt_src_t'(wb_dat_i[`LCDPT_SRC_LSB +: 2]);
          segments_on_gate_r <= wb_dat_i[`LCDPT_SON_BIT];
        end
        if (wb_sel_i[1]) begin
          base_clock_divider_r <= wb_dat_i[`LCDPT_DIV_LSB +: 5];
        end
        if (wb_sel_i[2] & wb_dat_i[`LCDPT_CLR_BIT]) begin
          memory_clear_request_r <= 1'b1;
        end
      end
    end
  end

  // Pin role and port function registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_role_select_reg_r <= `LCDPT_ROLE_RST;
      port_function_reg_r <= `LCDPT_PFUNC_RST;
    end else if (wr_en) begin
      for (int b = 0; b < 2; b++) begin
        if (wb_sel_i[b] && {word_idx, 2'b00} == `LCDPT_ROLE_OFS) begin
          pin_role_select_reg_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
        if (wb_sel_i[b] && {word_idx, 2'b00} == `LCDPT_PFUNC_OFS) begin
          port_function_reg_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
        end
      end
    end
  end

  // Display memory; a byte written at a frame boundary keeps the new value
  // Lane n of memory word w holds byte 4w+n
  genvar gb;
  generate
    for (gb = 0; gb < `LCDPT_NBYTES; gb++) begin : g_mem
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          display_memory_byte_r[gb] <= 8'h00;
        end else if (wr_en && word_idx == 6'(`LCDPT_MEM0_OFS / 4 + gb / 4)
                     && wb_sel_i[gb % 4]) begin
          display_memory_byte_r[gb] <= wb_dat_i[8*(gb % 4) +: 8];
        end else if (frame_end & memory_clear_request_r) begin
          display_memory_byte_r[gb] <= 8'h00;
        end
      end
    end
  endgenerate

  // Source choice and edge detection; the sources are slow, so sampling suffices
  always_comb begin
    unique case (timing_source_select_r)
      LCDPT_SRC_AUX: src_lvl = aux_clock_i;
      LCDPT_SRC_XTAL: src_lvl = crystal_32k_clock_i;
      LCDPT_SRC_VLO: src_lvl = very_low_power_osc_clock_i;
      LCDPT_SRC_NONE: src_lvl = 1'b0;
    endcase
  end
  assign src_edge = src_lvl & ~src_prev_r;

  // The programmable divider counts source edges, the fixed one counts its wraps; compares use >= so a lowered setting never stalls
  // A source level already high at reset release counts as one edge; every tick after it moves one source period earlier
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev_r <= 1'b0;
      pre_cnt_r <= 5'h00;
      mux_cnt_r <= 6'h00;
    end else begin
      src_prev_r <= src_lvl;
      if (src_edge) begin
        if (pre_cnt_r >= base_clock_divider_r) begin
          pre_cnt_r <= 5'h00;
          if (7'(mux_cnt_r) >= mux_div - 7'h01) begin
            mux_cnt_r <= 6'h00;
          end else begin
            mux_cnt_r <= mux_cnt_r + 6'h01;
          end
        end else begin
          pre_cnt_r <= pre_cnt_r + 5'h01;
        end
      end
    end
  end
  assign base_tick = src_edge && (pre_cnt_r >= base_clock_divider_r)
                     && (7'(mux_cnt_r) >= mux_div - 7'h01);

  // Frame phase: commons in order, then again with opposite polarity
  // Any mode change to a shorter frame may leave one out-of-range phase; the last branch mends it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_cnt_r <= 4'h0;
    end else if (base_tick) begin
      phase_cnt_r <= frame_end ? 4'h0 : phase_cnt_r + 4'h1;
    end else if (5'(phase_cnt_r) >= frame_len) begin
      phase_cnt_r <= 4'h0; // Mode changed to a shorter frame
    end
  end
  assign frame_end = base_tick && (5'(phase_cnt_r) >= frame_len - 5'h01);
  assign polarity_o = (phase_cnt_r >= mux_n);
  assign com_idx = polarity_o ? 3'(phase_cnt_r - mux_n) : phase_cnt_r[2:0];
  assign base_tick_o = base_tick;
  assign frame_start_o = frame_end;
  assign com_phase_o = com_idx;

  // Per-pin decode of role, memory and function
  genvar gp;
  generate
    for (gp = 0; gp < `LCDPT_NPINS; gp++) begin : g_pin
      logic [7:0] pair_byte; // Byte shared with the neighbour pin
      logic [3:0] nib; // This pin's nibble in the shared byte
      logic [7:0] sel_bits; // Segment data or common selection
      logic func; // Display function active
      logic [7:0] com_sel; // Common selection limited to this mode's commons
      assign pair_byte = display_memory_byte_r[gp / 2];
      assign nib = (gp % 2 == 1) ? pair_byte[7:4] : pair_byte[3:0];
      assign sel_bits = high_mux ? display_memory_byte_r[gp] : {4'h0, nib};
      // Masking means a stray selection bit above the mode's commons stays dark
      assign com_sel = sel_bits & com_mask;
      assign func = port_function_reg_r[gp] | dedicated_mask[gp];
      // Registered pin drive; software must keep one common bit per pin
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          seg_on_o[gp] <= 1'b0;
          com_active_o[gp] <= 1'b0;
          lcd_func_o[gp] <= 1'b0;
        end else begin
          lcd_func_o[gp] <= func;
          seg_on_o[gp] <= func & ~pin_role_select_reg_r[gp] & segments_on_gate_r
                          & sel_bits[com_idx];
          com_active_o[gp] <= func & pin_role_select_reg_r[gp]
                              & com_sel[com_idx];
        end
      end
    end
  endgenerate

  // Bus checks
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_ack_o) |=> wb_ack_o) else $error("request not answered next cycle");
  a_ack_data: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o == $past(rd_mux)) else $error("read data not from request cycle");

  // Clock and frame checks
  a_fixed_div: assert property (@(posedge clk_i) disable iff (rst_i)
    (mux_mode_select_r == LCDPT_STATIC |-> mux_div == 7'h40)
    and (mux_mode_select_r == LCDPT_MUX5 |-> mux_div == 7'h0C)
    and (mux_mode_select_r == LCDPT_MUX8 |-> mux_div == 7'h08))
    else $error("fixed divider wrong for mode");
  a_base_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    base_tick_o |-> src_edge ##1 (pre_cnt_r == 5'h00 && mux_cnt_r == 6'h00))
    else $error("base tick without counter wrap");
  a_tick_single: assert property (@(posedge clk_i) disable iff (rst_i)
    base_tick_o |=> !base_tick_o) else $error("base tick longer than one cycle");
  a_frame_len: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_start_o |-> base_tick_o && 5'(phase_cnt_r) == frame_len - 5'h01
    ##1 phase_cnt_r == 4'h0) else $error("frame length wrong");
  a_frame_pol: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_start_o |-> polarity_o) else $error("frame ends in first half");
  a_com_range: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(base_tick_o) |-> {1'b0, com_idx} < mux_n) else $error("common beyond mode");

  // Pin drive and memory checks
  a_seg_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !segments_on_gate_r ##1 !$past(rst_i) |-> seg_on_o == 16'h0000)
    else $error("segment lit with gate off");
  a_role_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    (seg_on_o & com_active_o) == 16'h0000) else $error("pin both segment and common");
  a_func_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    lcd_func_o == $past(port_function_reg_r | dedicated_mask))
    else $error("pin function not following its select bit");
  a_func_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ((seg_on_o | com_active_o) & ~lcd_func_o) == 16'h0000)
    else $error("drive on a digital pin");
  a_mem_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_start_o && memory_clear_request_r && !wr_en) |=>
    display_memory_byte_r[0] == 8'h00 && display_memory_byte_r[15] == 8'h00
    && !memory_clear_request_r) else $error("memory clear not done");
  a_clear_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (memory_clear_request_r && !frame_end) |=> memory_clear_request_r)
    else $error("clear request dropped before frame end");

endmodule : lcdpt_top
`default_nettype wire

// ### verif/lcdpt_glass.sv
// Behavioural display glass: records lit segments and driven commons per common phase
`timescale 1ns/1ns
`default_nettype none
module lcdpt_glass (
  input wire logic clk_i, // System clock
  input wire logic [15:0] seg_on_i, // Segment pins lit now
  input wire logic [15:0] com_active_i, // Pins driving the active common
  input wire logic [2:0] com_phase_i, // Active common index
  output logic [7:0][15:0] lit_o, // Lit segment pins seen per common
  output logic [7:0][15:0] drive_o // Pins seen driving each common
);
  // Glass is passive; last value of a phase wins, since pins lag the phase by one clock
  always_ff @(posedge clk_i) begin
    lit_o[com_phase_i] <= seg_on_i;
    drive_o[com_phase_i] <= com_active_i;
  end
endmodule : lcdpt_glass
`default_nettype wire

// ### verif/lcdpt_top_test.sv
// Self-checking bench of the display pin role and frame timing block
`timescale 1ns/1ns
`default_nettype none
`include "lcdpt_consts.svh"
module lcdpt_top_test;
  logic clk_i = 1'b0; // 125 MHz clock
  logic rst_i = 1'b1; // Synchronous reset
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus request
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic ack, aux = 1'b0, xtal = 1'b0, vlo = 1'b0; // Source levels
  logic [3:0] sc = 4'h0; // Source divider: aux 4, vlo 8, crystal 16 clocks
  logic [15:0] seg, com, func;
  logic tick, fst, pol;
  logic [2:0] ph;
  logic [7:0][15:0] lit, drv; // What the glass saw
  int miscompares = 0, n_compared = 0;
  int fd[8] = '{64, 32, 16, 16, 12, 8, 8, 8}; // Fixed divider per mode
  always #4 clk_i = ~clk_i;
  // Slow sources as clean dividers of the clock, so tick gaps are exact
  always @(posedge clk_i) begin
    sc <= sc + 4'h1;
    aux <= sc[1];
    vlo <= sc[2];
    xtal <= sc[3];
  end
  lcdpt_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .aux_clock_i(aux), .crystal_32k_clock_i(xtal), .very_low_power_osc_clock_i(vlo),
    .seg_on_o(seg), .com_active_o(com), .lcd_func_o(func), .base_tick_o(tick),
    .frame_start_o(fst), .com_phase_o(ph), .polarity_o(pol));
  lcdpt_glass u_glass (.clk_i(clk_i), .seg_on_i(seg), .com_active_i(com), .com_phase_i(ph),
    .lit_o(lit), .drive_o(drv));
  // Print counts and verdict, then stop
  task automatic final_report;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // One comparison; case inequality so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Classic single cycle; holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    chk(q, e);
  endtask : rd_chk
  // Second gap between base ticks, in clocks; the first may straddle a setting change
  task automatic gap_chk(input int e);
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (tick !== 1'b1 && n < 5000);
    end
    chk(32'(n), 32'(e));
  endtask : gap_chk
  // Base ticks from one frame start to the next; settle so every glass slot of the mode's commons is fresh
  task automatic frames(output int t);
    t = 0;
    do @(posedge clk_i); while (fst !== 1'b1);
    do begin
      @(posedge clk_i);
      if (tick === 1'b1) t++;
    end while (fst !== 1'b1);
    chk(32'(pol), 32'h1);
    repeat (3) @(posedge clk_i);
  endtask : frames
  // Defaults, unmapped place, byte lanes
  task automatic t_regs;
    logic [31:0] q;
    rd_chk(`LCDPT_CTRL_OFS, 32'h0400);
    rd_chk(`LCDPT_ROLE_OFS, 32'h0);
    rd_chk(`LCDPT_PFUNC_OFS, 32'h0);
    rd_chk(`LCDPT_STAT_OFS, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h0);
    wr(`LCDPT_MEM0_OFS, 32'h21);
    wb(1'b1, `LCDPT_MEM0_OFS, 32'hAAAA04BB, 4'h2, q);
    rd_chk(`LCDPT_MEM0_OFS, 32'h0421);
  endtask : t_regs
  // Every mode and source: base tick gap is (div+1) * fixed * source period
  task automatic t_timing;
    int n;
    for (int m = 0; m < 8; m++) begin
      wr(`LCDPT_CTRL_OFS, 32'h0400 | m);
      gap_chk(5 * fd[m] * 4);
    end
    wr(`LCDPT_CTRL_OFS, 32'h0417);
    gap_chk(5 * 8 * 16);
    wr(`LCDPT_CTRL_OFS, 32'h0427);
    gap_chk(5 * 8 * 8);
    wr(`LCDPT_CTRL_OFS, 32'h0437);
    n = 0;
    repeat (1000) begin
      @(posedge clk_i);
      if (tick === 1'b1) n++;
    end
    chk(32'(n), 32'h0);
  endtask : t_timing
  // 4-mux: two pins per byte, one common pin; then the gate blanks all
  task automatic t_mux4;
    int t;
    wr(`LCDPT_PFUNC_OFS, 32'hFFFF);
    wr(`LCDPT_ROLE_OFS, 32'h4);
    wr(`LCDPT_CTRL_OFS, 32'h0483);
    frames(t);
    frames(t);
    chk(32'(t), 32'h8);
    chk(32'(lit[0]), 32'h1);
    chk(32'(lit[1]), 32'h2);
    chk(32'(drv[2]), 32'h4);
    chk(32'(drv[0]), 32'h0);
    chk(32'(func), 32'hFFFF);
    chk(32'({pol, ph}), 32'h0);
    wr(`LCDPT_CTRL_OFS, 32'h0403);
    frames(t);
    frames(t);
    chk(32'(lit[0]), 32'h0);
  endtask : t_mux4
  // Static mode accepts common 0 only
  task automatic t_static;
    int t;
    wr(`LCDPT_MEM0_OFS, 32'h0200);
    wr(`LCDPT_CTRL_OFS, 32'h0480);
    frames(t);
    frames(t);
    chk(32'(drv[0]), 32'h0);
    wr(`LCDPT_MEM0_OFS, 32'h0100);
    frames(t);
    frames(t);
    chk(32'(drv[0]), 32'h4);
  endtask : t_static
  // 8-mux: one byte per pin, byte picks the common; then memory clear
  task automatic t_mux8;
    int t, k;
    logic [31:0] q;
    wr(`LCDPT_MEM0_OFS, 32'h80);
    wr(8'h14, 32'h40);
    wr(`LCDPT_ROLE_OFS, 32'h10);
    wr(`LCDPT_CTRL_OFS, 32'h0487);
    frames(t);
    frames(t);
    chk(32'(t), 32'h10);
    chk(32'(drv[6]), 32'h10);
    chk(32'(lit[7]), 32'h1);
    chk(32'(lit[6]), 32'h0);
    wr(`LCDPT_CTRL_OFS, 32'h10487);
    k = 0;
    do begin
      wb(1'b0, `LCDPT_CTRL_OFS, 32'h0, 4'hF, q);
      k++;
    end while (q[16] !== 1'b0 && k < 2000);
    chk(q, 32'h0487);
    rd_chk(`LCDPT_MEM0_OFS, 32'h0);
    rd_chk(8'h14, 32'h0);
    wr(`LCDPT_PFUNC_OFS, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(32'(func), 32'h0);
  endtask : t_mux8
  // Whole run is at most about 66k clocks; the limit leaves room and stays under 100k
  initial begin
    repeat (90000) @(posedge clk_i);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_timing();
    t_mux4();
    t_static();
    t_mux8();
    final_report();
  end
endmodule : lcdpt_top_test
`default_nettype wire
